// ===== hdl/lmu_pkg.sv
// Purpose: Shared constants and types for the serial slave and pin logic
// Assumes: Eight-bit register index and data on the serial link
// Notes: Register values below are reset values of the pin logic
package lmu_pkg;
  localparam logic [6:0] LMU_SLAVE_ADDR = 7'h59;
  localparam logic [7:0] LMU_REG_PIN_CTRL = 8'h06;
  localparam logic [7:0] LMU_REG_PIN_LEVELS = 8'h07;
  localparam int LMU_NUM_PINS = 3;
  localparam int LMU_DIR_LSB = 0;
  localparam int LMU_PWM_SEL_BIT = 4;
  localparam logic [7:0] LMU_CTRL_MASK = 8'h17;
  localparam logic [2:0] LMU_DIR_RST = 3'h0;
  localparam logic [2:0] LMU_LEVEL_RST = 3'h0;
  localparam logic LMU_PWM_SEL_RST = 1'h0;
  localparam logic [3:0] LMU_BYTE_BITS = 4'h8;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } lmu_wr_t;

  typedef struct packed {
    logic [LMU_NUM_PINS-1:0] level;
    logic [LMU_NUM_PINS-1:0] oe;
  } lmu_gpio_t;
endpackage

// ===== hdl/lmu_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output rises once stages two and three are both high, falls as soon as they differ
`timescale 1ns/1ps
module lmu_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;
  logic [W-1:0] outNext;

  // Per bit: set when both late stages are high, clear when they differ, else hold
  assign outNext = (s2Reg & s3Reg) | (dout & ~(s2Reg ^ s3Reg));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1Reg <= RST;
      s2Reg <= RST;
      s3Reg <= RST;
      dout <= RST;
    end else begin
      s1Reg <= din;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      dout <= outNext;
    end
  end
endmodule

// ===== hdl/lmu_i2c_gpio.sv
// Purpose: Serial slave port and three-pin general purpose I/O logic
// Assumes: linkClk oversamples SCL; rstn is synchronous, active low
// Notes: Register file lives on clk, bit engine on linkClk
`timescale 1ns/1ps
// Summary of operation
// - Direction bit one drives the pin with its level register bit.
// - PWM select set makes pin 0 a PWM input, ignoring its direction.
// - Only pin 0 has PWM; pins 1 and 2 follow their direction bits.
// - Output pins drive the written level register value.
// - Reading the level register returns live sampled pin levels.
// - Data changes only while SCL low, except start and stop.
// - Start is SDA falling with SCL high; stop is SDA rising.
// - Bus busy from start until stop, idle after stop.
// - Repeated start restarts address reception like a first start.
// - Bytes are eight bits, MSB first, then one acknowledge slot.
// - Ninth clock: transmitter releases SDA, receiver pulls it low.
// - Once addressed, the receiving slave acknowledges every byte.
// - First byte is 7-bit address plus direction; only own address answers.
// - In a write, next byte is register index, then the data.
// - Written value takes effect at the last slave acknowledge rising edge.
// - Control bits 2 to 0 set each pin direction, one is output.
// - Control bit 4 is the PWM input select.
module lmu_i2c_gpio (
  input wire logic clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [lmu_pkg::LMU_NUM_PINS-1:0] gpioIn,
  output lmu_pkg::lmu_gpio_t gpioDrive,
  output logic pwmInput,
  output logic busBusy
);
  import lmu_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_IDX, ST_IDX_ACK, ST_DATA, ST_DATA_ACK,
    ST_TX, ST_TX_ACK, ST_TX_NEXT, ST_WAIT
  } lmu_state_t;

  // ---------------- Link domain ----------------
  logic rstMetaReg;
  logic linkRstn;
  logic sclS;
  logic sdaS;
  logic sclPrevReg;
  logic sdaPrevReg;
  lmu_state_t stReg;
  logic [3:0] bitCnt;
  logic [7:0] shReg;
  logic rwReg;
  logic [7:0] idxReg;
  logic sdaOeReg;
  logic wrTglReg;
  logic rdTglReg;
  lmu_wr_t wrWordReg;
  logic busyReg;
  logic [7:0] holdReg;

  // Reset release brought into the link domain
  always_ff @(posedge linkClk) begin
    rstMetaReg <= rstn;
    linkRstn <= rstMetaReg;
  end

  lmu_sync3 #(.W(2), .RST(2'h3)) uLinkSync (
    .clk(linkClk),
    .rstn(linkRstn),
    .din({sclIn, sdaIn}),
    .dout({sclS, sdaS})
  );

  wire sclRise = sclS & ~sclPrevReg;
  wire sclFall = ~sclS & sclPrevReg;
  wire startDet = sclS & sclPrevReg & sdaPrevReg & ~sdaS;
  wire stopDet = sclS & sclPrevReg & ~sdaPrevReg & sdaS;
  wire byteDone = sclFall && (bitCnt == LMU_BYTE_BITS);
  wire addrHit = (shReg[7:1] == LMU_SLAVE_ADDR);
  wire rxState = (stReg == ST_ADDR) || (stReg == ST_IDX) || (stReg == ST_DATA);

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      sclPrevReg <= 1'b1;
      sdaPrevReg <= 1'b1;
      busyReg <= 1'b0;
    end else begin
      sclPrevReg <= sclS;
      sdaPrevReg <= sdaS;
      if (startDet) begin
        busyReg <= 1'b1;
      end else if (stopDet) begin
        busyReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      stReg <= ST_IDLE;
      bitCnt <= 4'h0;
      shReg <= 8'h00;
      rwReg <= 1'b0;
      idxReg <= 8'h00;
      sdaOeReg <= 1'b0;
      wrTglReg <= 1'b0;
      rdTglReg <= 1'b0;
      wrWordReg <= '0;
    end else if (startDet) begin
      // Repeated start is handled exactly like a first start
      stReg <= ST_ADDR;
      bitCnt <= 4'h0;
      sdaOeReg <= 1'b0;
    end else if (stopDet) begin
      stReg <= ST_IDLE;
      sdaOeReg <= 1'b0;
    end else begin
      case (stReg)
        ST_ADDR, ST_IDX, ST_DATA: begin
          if (sclRise) begin
            shReg <= {shReg[6:0], sdaS};
            bitCnt <= bitCnt + 4'h1;
          end else if (byteDone) begin
            bitCnt <= 4'h0;
            if (stReg == ST_ADDR) begin
              if (addrHit) begin
                sdaOeReg <= 1'b1;
                rwReg <= shReg[0];
                stReg <= ST_ADDR_ACK;
                // Ask for the read value early; it is used at the SCL fall that ends the acknowledge slot
                if (shReg[0]) begin
                  rdTglReg <= ~rdTglReg;
                end
              end else begin
                stReg <= ST_WAIT;
              end
            end else if (stReg == ST_IDX) begin
              sdaOeReg <= 1'b1;
              idxReg <= shReg;
              stReg <= ST_IDX_ACK;
            end else begin
              sdaOeReg <= 1'b1;
              stReg <= ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            if (rwReg) begin
              shReg <= holdReg;
              sdaOeReg <= ~holdReg[7];
              bitCnt <= 4'h1;
              stReg <= ST_TX;
            end else begin
              sdaOeReg <= 1'b0;
              stReg <= ST_IDX;
            end
          end
        end
        ST_IDX_ACK: begin
          if (sclFall) begin
            sdaOeReg <= 1'b0;
            stReg <= ST_DATA;
          end
        end
        ST_DATA_ACK: begin
          if (sclRise) begin
            wrWordReg <= '{idx: idxReg, data: shReg};
            wrTglReg <= ~wrTglReg;
          end else if (sclFall) begin
            sdaOeReg <= 1'b0;
            stReg <= ST_DATA;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt == LMU_BYTE_BITS) begin
              sdaOeReg <= 1'b0;
              rdTglReg <= ~rdTglReg;
              stReg <= ST_TX_ACK;
            end else begin
              shReg <= {shReg[6:0], 1'b0};
              sdaOeReg <= ~shReg[6];
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (sclRise) begin
            stReg <= sdaS ? ST_WAIT : ST_TX_NEXT;
          end
        end
        ST_TX_NEXT: begin
          if (sclFall) begin
            shReg <= holdReg;
            sdaOeReg <= ~holdReg[7];
            bitCnt <= 4'h1;
            stReg <= ST_TX;
          end
        end
        ST_WAIT: begin
          sdaOeReg <= 1'b0;
        end
        default: begin
          stReg <= ST_IDLE;
          sdaOeReg <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOeReg;
  assign busBusy = busyReg;

  // ---------------- Register domain ----------------
  logic wrTglS;
  logic rdTglS;
  logic wrTglPrevReg;
  logic rdTglPrevReg;
  logic [LMU_NUM_PINS-1:0] pinS;
  logic [2:0] dirReg;
  logic pwmSelReg;
  logic [2:0] levelReg;

  lmu_sync3 #(.W(2), .RST(2'h0)) uTglSync (
    .clk(clk),
    .rstn(rstn),
    .din({wrTglReg, rdTglReg}),
    .dout({wrTglS, rdTglS})
  );

  lmu_sync3 #(.W(LMU_NUM_PINS), .RST(3'h0)) uPinSync (
    .clk(clk),
    .rstn(rstn),
    .din(gpioIn),
    .dout(pinS)
  );

  // Word stays put after its toggle, so capture on the toggle edge is safe
  wire wrPulse = wrTglS ^ wrTglPrevReg;
  wire rdPulse = rdTglS ^ rdTglPrevReg;
  wire wrCtrl = wrPulse && (wrWordReg.idx == LMU_REG_PIN_CTRL);
  wire wrLevel = wrPulse && (wrWordReg.idx == LMU_REG_PIN_LEVELS);
  wire [7:0] ctrlView = {3'h0, pwmSelReg, 1'b0, dirReg} & LMU_CTRL_MASK;
  wire [7:0] levelView = {5'h00, pinS};
  wire [7:0] rdValue = (idxReg == LMU_REG_PIN_CTRL) ? ctrlView :
                       (idxReg == LMU_REG_PIN_LEVELS) ? levelView : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrTglPrevReg <= 1'b0;
      rdTglPrevReg <= 1'b0;
      dirReg <= LMU_DIR_RST;
      pwmSelReg <= LMU_PWM_SEL_RST;
      levelReg <= LMU_LEVEL_RST;
      holdReg <= 8'h00;
    end else begin
      wrTglPrevReg <= wrTglS;
      rdTglPrevReg <= rdTglS;
      if (wrCtrl) begin
        dirReg <= wrWordReg.data[LMU_DIR_LSB +: 3];
        pwmSelReg <= wrWordReg.data[LMU_PWM_SEL_BIT];
      end
      if (wrLevel) begin
        levelReg <= wrWordReg.data[2:0];
      end
      if (rdPulse) begin
        holdReg <= rdValue;
      end
    end
  end

  // PWM select takes pin 0 away from its direction bit
  // One driver for the whole struct; split member assigns upset some tools
  assign gpioDrive = '{level: levelReg,
                       oe: {dirReg[2:1], dirReg[0] & ~pwmSelReg}};
  assign pwmInput = pwmSelReg & pinS[0];

  // ---------------- Checks ----------------
  chk_pwm_override: assert property (@(posedge clk) disable iff (!rstn)
    pwmSelReg |-> !gpioDrive.oe[0]) else $error("pin 0 driven while PWM select set");
  chk_pin12_dir: assert property (@(posedge clk) disable iff (!rstn)
    wrCtrl |=> gpioDrive.oe[2:1] == $past(wrWordReg.data[2:1]))
    else $error("pin 1/2 direction not taken from write");
  chk_level_drive: assert property (@(posedge clk) disable iff (!rstn)
    wrLevel ##1 gpioDrive.oe[1] |-> gpioDrive.level[1] == $past(wrWordReg.data[1]))
    else $error("output level differs from written value");
  chk_read_live: assert property (@(posedge clk) disable iff (!rstn)
    rdPulse && idxReg == LMU_REG_PIN_LEVELS |=> holdReg[2:0] == $past(pinS))
    else $error("level read not live pin state");
  chk_level_upper: assert property (@(posedge clk) disable iff (!rstn)
    rdPulse && idxReg == LMU_REG_PIN_LEVELS |=> holdReg[7:3] == 5'h00)
    else $error("level read upper bits not zero");
  chk_busy_span: assert property (@(posedge linkClk) disable iff (!linkRstn)
    startDet |=> busyReg)
    else $error("busy not set after start");
  chk_busy_hold: assert property (@(posedge linkClk) disable iff (!linkRstn)
    busyReg && !stopDet |=> busyReg)
    else $error("busy dropped before stop");
  chk_busy_idle: assert property (@(posedge linkClk) disable iff (!linkRstn)
    stopDet |=> !busyReg)
    else $error("bus not idle after stop");
  chk_stop_state: assert property (@(posedge linkClk) disable iff (!linkRstn)
    stopDet |=> stReg == ST_IDLE && !sdaOeReg)
    else $error("engine not idle after stop");
  chk_addr_ignore: assert property (@(posedge linkClk) disable iff (!linkRstn)
    byteDone && stReg == ST_ADDR && !addrHit && !startDet && !stopDet
    |=> stReg == ST_WAIT && !sdaOeReg)
    else $error("foreign address answered");
  chk_tx_release: assert property (@(posedge linkClk) disable iff (!linkRstn)
    sclFall && stReg == ST_TX && bitCnt == LMU_BYTE_BITS && !startDet && !stopDet
    |=> stReg == ST_TX_ACK && !sdaOeReg)
    else $error("SDA not released for acknowledge");
  chk_tx_msb: assert property (@(posedge linkClk) disable iff (!linkRstn)
    sclFall && stReg == ST_ADDR_ACK && rwReg && !startDet && !stopDet
    |=> sdaOeReg == !$past(holdReg[7]) && bitCnt == 4'h1)
    else $error("first read bit wrong");
  chk_start_addr: assert property (@(posedge linkClk) disable iff (!linkRstn)
    startDet |=> stReg == ST_ADDR && bitCnt == 4'h0 && !sdaOeReg)
    else $error("start did not restart address reception");
  chk_ack_drive: assert property (@(posedge linkClk) disable iff (!linkRstn)
    byteDone && !startDet && !stopDet && (stReg == ST_IDX || stReg == ST_DATA)
    |=> sdaOeReg) else $error("received byte not acknowledged");
  chk_sda_stable: assert property (@(posedge linkClk) disable iff (!linkRstn)
    $changed(sdaOeReg) && !$past(startDet) && !$past(stopDet) |-> !sclS)
    else $error("SDA changed while SCL high");
  chk_write_commit: assert property (@(posedge linkClk) disable iff (!linkRstn)
    sclRise && stReg == ST_DATA_ACK && !startDet && !stopDet |=> wrTglReg != $past(wrTglReg))
    else $error("write not committed at acknowledge rise");
  chk_nack_release: assert property (@(posedge linkClk) disable iff (!linkRstn)
    sclRise && stReg == ST_TX_ACK && sdaS && !startDet && !stopDet
    |=> stReg == ST_WAIT ##1 !sdaOeReg) else $error("no release after not-acknowledge");

  cov_write: cover property (@(posedge linkClk) disable iff (!linkRstn)
    sclRise && stReg == ST_DATA_ACK);
  cov_read: cover property (@(posedge linkClk) disable iff (!linkRstn)
    stReg == ST_ADDR_ACK && rwReg ##[1:200] stReg == ST_TX);
  cov_repeat_start: cover property (@(posedge linkClk) disable iff (!linkRstn)
    startDet && busyReg);
  cov_pwm: cover property (@(posedge clk) disable iff (!rstn) wrCtrl ##1 pwmSelReg);
  cov_read_more: cover property (@(posedge linkClk) disable iff (!linkRstn)
    stReg == ST_TX_NEXT && sclFall);
endmodule

// ===== dv/lmu_i2c_master.sv
// Purpose: Behavioural serial bus master on the clock and data lines
// Assumes: Data line is open drain with a pull-up outside
// Notes: Quarter bit of QTR clk cycles keeps clock low time above 1.3 us
`timescale 1ns/1ps
module lmu_i2c_master #(
  parameter int QTR = 10
) (
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic qwait();
    repeat (QTR) @(posedge clk);
    #1;
  endtask
  // Also serves as repeated start
  task automatic start();
    sdaPull = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sdaPull = 1'b1;
    qwait();
    scl = 1'b0;
    qwait();
  endtask
  task automatic stop();
    sdaPull = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sdaPull = 1'b0;
    qwait();
  endtask
  // Data moves only while the clock is low
  task automatic bitIo(input logic b, output logic got);
    sdaPull = ~b;
    qwait();
    scl = 1'b1;
    qwait();
    got = sdaWire;
    qwait();
    scl = 1'b0;
    qwait();
  endtask
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], g);
    end
    bitIo(1'b1, g);
    ack = ~g;
  endtask
  task automatic readByte(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, g);
      d[i] = g;
    end
    bitIo(nack, g);
  endtask
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the serial slave and pin logic
// Assumes: Master model on the bus; driven pins loop back to their inputs
// Notes: Random register and pin values from a fixed seed
`timescale 1ns/1ps
module testbench;
  import lmu_pkg::*;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rstn = 1'b0;
  logic scl;
  logic sdaPull;
  logic sdaOut;
  logic sdaOe;
  logic sdaWire;
  logic pwmInput;
  logic busBusy;
  logic [2:0] extPins = 3'h0;
  logic [2:0] gpioIn;
  lmu_gpio_t gpioDrive;
  int failures = 0;
  int numChecks = 0;
  int cycles = 0;
  integer seed = 32'h2307;
  logic ack;
  logic [7:0] rd;
  logic [7:0] ctrl;
  logic [7:0] lvl;

  always #50 clk = ~clk;
  always #32 linkClk = ~linkClk;
  // Pull-up wins unless someone pulls low
  assign sdaWire = ~(sdaPull | (sdaOe & ~sdaOut));
  assign gpioIn = (gpioDrive.oe & gpioDrive.level) | (~gpioDrive.oe & extPins);

  lmu_i2c_master u_master (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));
  lmu_i2c_gpio u_dut (.clk(clk), .rstn(rstn), .linkClk(linkClk), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .gpioIn(gpioIn),
    .gpioDrive(gpioDrive), .pwmInput(pwmInput), .busBusy(busBusy));

  function automatic logic [2:0] expOe(input logic [7:0] c);
    return c[2:0] & ~{2'h0, c[4]};
  endfunction
  function automatic logic [7:0] expPins(input logic [7:0] c, input logic [7:0] l,
    input logic [2:0] e);
    logic [2:0] o;
    o = expOe(c);
    return {5'h00, (o & l[2:0]) | (~o & e)};
  endfunction

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask
  task automatic test_done();
    if (failures == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
    u_master.start();
    u_master.writeByte({LMU_SLAVE_ADDR, 1'b0}, ack);
    check("addr ack", 8'h01, {7'h00, ack});
    check("busy", 8'h01, {7'h00, busBusy});
    u_master.writeByte(idx, ack);
    check("index ack", 8'h01, {7'h00, ack});
    u_master.writeByte(d, ack);
    check("data ack", 8'h01, {7'h00, ack});
    // Before stop: effect must not wait for the stop
    if (idx === LMU_REG_PIN_LEVELS) begin
      check("early level", {5'h00, d[2:0]}, {5'h00, gpioDrive.level});
    end
    u_master.stop();
    check("idle", 8'h00, {7'h00, busBusy});
  endtask
  task automatic rdReg(input logic [7:0] idx, input logic [7:0] exp, input int extra = 0);
    u_master.start();
    u_master.writeByte({LMU_SLAVE_ADDR, 1'b0}, ack);
    u_master.writeByte(idx, ack);
    u_master.start();
    u_master.writeByte({LMU_SLAVE_ADDR, 1'b1}, ack);
    check("read addr ack", 8'h01, {7'h00, ack});
    // Master acknowledge asks for the same register again
    for (int k = 0; k < extra; k++) begin
      u_master.readByte(1'b0, rd);
      check("read again", exp, rd);
    end
    u_master.readByte(1'b1, rd);
    check("read data", exp, rd);
    check("released", 8'h00, {7'h00, sdaOe});
    u_master.stop();
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    check("reset drive", 8'h00, {2'h0, gpioDrive});
    check("reset flags", 8'h00, {5'h00, pwmInput, sdaOe, busBusy});
    repeat (10) @(posedge clk);
    #1;
    u_master.start();
    u_master.writeByte(8'hB4, ack);
    check("foreign ack", 8'h00, {7'h00, ack});
    u_master.stop();
    for (int i = 0; i < 8; i++) begin
      ctrl = 8'($random(seed));
      lvl = 8'($random(seed));
      // Corners: all bits set, then outputs with low levels
      if (i < 2) begin
        ctrl = i ? 8'h07 : 8'hFF;
        lvl = i ? 8'h00 : 8'hFF;
      end
      @(posedge clk);
      #1;
      extPins = 3'($random(seed));
      wrReg(LMU_REG_PIN_CTRL, ctrl);
      wrReg(LMU_REG_PIN_LEVELS, lvl);
      check("oe", {5'h00, expOe(ctrl)}, {5'h00, gpioDrive.oe});
      check("level", {5'h00, lvl[2:0]}, {5'h00, gpioDrive.level});
      check("pwm", {7'h00, ctrl[4] & extPins[0]}, {7'h00, pwmInput});
      rdReg(LMU_REG_PIN_LEVELS, expPins(ctrl, lvl, extPins));
      rdReg(LMU_REG_PIN_CTRL, ctrl & LMU_CTRL_MASK, 1);
    end
    rdReg(8'h10, 8'h00);
    test_done();
  end
endmodule
